// [hdl/cfgnvm_ctrl.sv]
`timescale 1ns/1ps
module cfgnvm_ctrl (
  input  wire logic                       ref_clk,
  input  wire logic                       reset,
  input  wire cfgnvm_pkg::cfgnvm_reg_req_s reg_req,
  output logic      [7:0]                 reg_rdata,
  input  wire logic                       nvm_sel_n,
  input  wire logic                       status_sel,
  output logic                            status_pin,
  output logic                            apply_staged,
  output logic                            soft_reset,
  output cfgnvm_pkg::cfgnvm_buf_req_s     buf_req,
  input  wire logic [7:0]                 buf_rdata,
  output cfgnvm_pkg::cfgnvm_nvm_req_s     nvm_req,
  input  wire cfgnvm_pkg::cfgnvm_nvm_rsp_s nvm_rsp
);

  typedef struct packed {
    cfgnvm_pkg::cfgnvm_state_e         st;
    logic [cfgnvm_pkg::TIX_W-1:0]      tix;
    logic [cfgnvm_pkg::CNT_W-1:0]      cnt;
    logic [cfgnvm_pkg::AW-1:0]         addr;
    logic                              load;
    logic                              busy;
    logic                              err;
    logic                              wr_en;
    logic                              store;
    logic                              apply;
    logic                              srst;
    logic                              pin;
    logic [7:0]                        rdata;
    logic [cfgnvm_pkg::TBL_N*8-1:0]    tbl;
    cfgnvm_pkg::cfgnvm_buf_req_s       bufr;
    cfgnvm_pkg::cfgnvm_nvm_req_s       nvm;
  } cfgnvm_regs_s;

  cfgnvm_regs_s s_q;
  cfgnvm_regs_s s_d;

  function automatic logic in_tbl(input logic [cfgnvm_pkg::AW-1:0] a);
    return (a >= cfgnvm_pkg::ADDR_TBL_LO) && (a <= cfgnvm_pkg::ADDR_TBL_HI);
  endfunction

  function automatic logic [7:0] tbl_byte(input logic [cfgnvm_pkg::TBL_N*8-1:0] t,
                                          input logic [cfgnvm_pkg::TIX_W-1:0] i);
    return (i < cfgnvm_pkg::TIX_W'(cfgnvm_pkg::TBL_N)) ? t[i*8 +: 8] : cfgnvm_pkg::OP_END;
  endfunction

  logic                          wr_store;
  logic                          wr_reload;
  logic                          wr_apply;
  logic [cfgnvm_pkg::TIX_W-1:0]  wr_idx;
  logic [7:0]                    ent0;
  logic [7:0]                    ent1;
  logic [7:0]                    ent2;

  assign wr_apply  = reg_req.wr && reg_req.addr == cfgnvm_pkg::ADDR_APPLY
                     && reg_req.wdata[cfgnvm_pkg::BIT_TRIG];
  assign wr_store  = reg_req.wr && reg_req.addr == cfgnvm_pkg::ADDR_STORE
                     && reg_req.wdata[cfgnvm_pkg::BIT_TRIG];
  assign wr_reload = reg_req.wr && reg_req.addr == cfgnvm_pkg::ADDR_CONTROL
                     && reg_req.wdata[cfgnvm_pkg::BIT_RELOAD];
  assign wr_idx    = cfgnvm_pkg::TIX_W'(reg_req.addr - cfgnvm_pkg::ADDR_TBL_LO);
  assign ent0      = tbl_byte(s_q.tbl, s_q.tix);
  assign ent1      = tbl_byte(s_q.tbl, s_q.tix + 5'h01);
  assign ent2      = tbl_byte(s_q.tbl, s_q.tix + 5'h02);

  always_comb begin
    s_d          = s_q;
    s_d.apply    = 1'b0;
    s_d.srst     = 1'b0;
    s_d.bufr.we  = 1'b0;

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == cfgnvm_pkg::ADDR_CONTROL) begin
        s_d.wr_en = reg_req.wdata[cfgnvm_pkg::BIT_WR_EN];
      end
      // Table is frozen while the walker reads it
      if (in_tbl(reg_req.addr) && !s_q.busy) begin
        s_d.tbl[wr_idx*8 +: 8] = reg_req.wdata;
      end
    end
    if (wr_apply) begin
      s_d.apply = 1'b1;
    end

    unique case (s_q.st)
      cfgnvm_pkg::CFGNVM_IDLE: begin
        // Refused store sets nothing: no busy, no store bit
        if (wr_store && s_q.wr_en) begin
          s_d.store = 1'b1;
          s_d.load  = 1'b0;
          s_d.busy  = 1'b1;
          s_d.err   = 1'b0;
          s_d.tix   = '0;
          s_d.nvm.addr = '0;
          s_d.st    = cfgnvm_pkg::CFGNVM_ENTRY;
        end else if (wr_reload && !nvm_sel_n) begin
          s_d.srst  = 1'b1;
          s_d.load  = 1'b1;
          s_d.busy  = 1'b1;
          s_d.err   = 1'b0;
          s_d.tix   = '0;
          s_d.nvm.addr = '0;
          s_d.st    = cfgnvm_pkg::CFGNVM_ENTRY;
        end
      end
      cfgnvm_pkg::CFGNVM_ENTRY: begin
        if (ent0 == cfgnvm_pkg::OP_END) begin
          s_d.busy  = 1'b0;
          s_d.store = 1'b0;
          s_d.st    = cfgnvm_pkg::CFGNVM_IDLE;
        end else if (ent0 == cfgnvm_pkg::OP_APPLY) begin
          // Applying on a store would discard nothing but is pointless
          // Host apply write in the same cycle must still land
          s_d.apply = s_d.apply || s_q.load;
          s_d.tix   = s_q.tix + 1'b1;
        end else if (ent0[cfgnvm_pkg::OP_FLAG]) begin
          s_d.tix   = s_q.tix + 1'b1;
        end else begin
          s_d.cnt   = ent0[cfgnvm_pkg::CNT_W-1:0];
          s_d.addr  = {ent1[3:0], ent2};
          s_d.tix   = s_q.tix + cfgnvm_pkg::ENTRY_LEN;
          s_d.bufr.addr = s_d.addr;
          s_d.st    = s_q.load ? cfgnvm_pkg::CFGNVM_NVM : cfgnvm_pkg::CFGNVM_BUF;
        end
      end
      cfgnvm_pkg::CFGNVM_BUF: begin
        s_d.nvm.wdata = buf_rdata;
        s_d.nvm.we    = 1'b1;
        s_d.nvm.req   = s_q.wr_en;
        s_d.st        = cfgnvm_pkg::CFGNVM_NVM;
      end
      cfgnvm_pkg::CFGNVM_NVM: begin
        s_d.nvm.we  = !s_q.load && s_q.wr_en;
        s_d.nvm.req = 1'b1;
        if (s_q.nvm.req && nvm_rsp.ack) begin
          s_d.nvm.req  = 1'b0;
          s_d.nvm.we   = 1'b0;
          s_d.err      = s_q.err | nvm_rsp.err;
          s_d.nvm.addr = s_q.nvm.addr + 1'b1;
          s_d.addr     = s_q.addr + 1'b1;
          s_d.cnt      = s_q.cnt - 1'b1;
          if (s_q.load) begin
            s_d.bufr.we    = 1'b1;
            s_d.bufr.addr  = s_q.addr;
            s_d.bufr.wdata = nvm_rsp.rdata;
          end else begin
            s_d.bufr.addr  = s_q.addr + 1'b1;
          end
          if (s_q.cnt == '0) begin
            s_d.st = cfgnvm_pkg::CFGNVM_ENTRY;
          end else begin
            s_d.st = s_q.load ? cfgnvm_pkg::CFGNVM_NVM : cfgnvm_pkg::CFGNVM_BUF;
          end
        end
      end
    endcase

    s_d.pin = status_sel && s_d.busy;

    // Registered read, one cycle of latency
    if (in_tbl(reg_req.addr)) begin
      s_d.rdata = tbl_byte(s_q.tbl, wr_idx);
    end else begin
      unique case (reg_req.addr)
        cfgnvm_pkg::ADDR_APPLY:   s_d.rdata = {7'h00, s_q.apply};
        cfgnvm_pkg::ADDR_STATUS:  s_d.rdata = {7'h00, s_q.busy};
        cfgnvm_pkg::ADDR_ERROR:   s_d.rdata = {7'h00, s_q.err};
        cfgnvm_pkg::ADDR_CONTROL: s_d.rdata = {6'h00, 1'b0, s_q.wr_en};
        cfgnvm_pkg::ADDR_STORE:   s_d.rdata = {7'h00, s_q.store};
        default:                  s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q       <= '0;
      s_q.st    <= cfgnvm_pkg::CFGNVM_IDLE;
      s_q.tbl   <= cfgnvm_pkg::TBL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata    = s_q.rdata;
  assign status_pin   = s_q.pin;
  assign apply_staged = s_q.apply;
  assign soft_reset   = s_q.srst;
  assign buf_req      = s_q.bufr;
  assign nvm_req      = s_q.nvm;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  apply_pulse_a: assert property (wr_apply |=> apply_staged)
    else $error("apply write did not commit staged registers");
  apply_clear_a: assert property (apply_staged && !wr_apply && !s_q.busy |=> !apply_staged)
    else $error("apply bit did not self-clear");
  store_start_a: assert property (wr_store && s_q.wr_en && !s_q.busy |=> s_q.busy && s_q.store)
    else $error("store did not start");
  store_refuse_a: assert property (wr_store && !s_q.wr_en && !s_q.busy
                                   |=> (!s_q.busy && !s_q.store) ##1 !s_q.store)
    else $error("protected store showed activity");
  status_pin_a: assert property (status_sel |=> status_pin == s_q.busy)
    else $error("status pin does not follow transfer");
  // Write enable is sampled one cycle before the request goes out
  nvm_guard_a: assert property (nvm_req.req && nvm_req.we |-> $past(s_q.wr_en))
    else $error("nvm write while protected");
  store_done_a: assert property ($fell(s_q.busy) && !s_q.load |-> !s_q.store)
    else $error("store bit stuck after completion");
  reload_go_a: assert property (wr_reload && !nvm_sel_n && !s_q.busy
                                |=> soft_reset && s_q.busy ##1 !soft_reset)
    else $error("reload did not reset and load");
  error_flag_a: assert property (nvm_req.req && nvm_rsp.ack && nvm_rsp.err |=> s_q.err)
    else $error("nvm data error not flagged");
  busy_read_a: assert property (reg_req.addr == cfgnvm_pkg::ADDR_STATUS && !reg_req.wr
                                |=> reg_rdata[0] == $past(s_q.busy))
    else $error("status read mismatch");

  store_done_c: cover property (s_q.busy && !s_q.load ##1 !s_q.busy);
  load_done_c:  cover property (s_q.busy && s_q.load ##1 !s_q.busy);
  op_apply_c:   cover property (s_q.load && apply_staged);
  err_seen_c:   cover property ($rose(s_q.err));

endmodule // cfgnvm_ctrl

// [hdl/cfgnvm_pkg.sv]
package cfgnvm_pkg;

  localparam int unsigned AW      = 12;
  localparam int unsigned TBL_N   = 23;
  localparam int unsigned TIX_W   = 5;
  localparam int unsigned CNT_W   = 7;

  // Register byte addresses
  localparam logic [11:0] ADDR_APPLY   = 12'h232;
  localparam logic [11:0] ADDR_TBL_LO  = 12'hA00;
  localparam logic [11:0] ADDR_TBL_HI  = 12'hA16;
  localparam logic [11:0] ADDR_STATUS  = 12'hB00;
  localparam logic [11:0] ADDR_ERROR   = 12'hB01;
  localparam logic [11:0] ADDR_CONTROL = 12'hB02;
  localparam logic [11:0] ADDR_STORE   = 12'hB03;

  // Bit positions
  localparam int unsigned BIT_TRIG   = 0;
  localparam int unsigned BIT_WR_EN  = 0;
  localparam int unsigned BIT_RELOAD = 1;

  // Segment table encoding: range entry is three bytes,
  // {0,count-1[6:0]}, {0000,addr[11:8]}, addr[7:0]; opcodes are one byte
  localparam logic [7:0] OP_APPLY  = 8'h80;
  localparam logic [7:0] OP_END    = 8'hFF;
  localparam int unsigned OP_FLAG  = 7;
  localparam logic [TIX_W-1:0] ENTRY_LEN = 5'h03;

  // Ranges 0x000-0x23F, then apply, then end (byte 0 in the low bits)
  localparam logic [TBL_N*8-1:0] TBL_RST =
    184'hFFFFFFFFFFFFFF8000023F80017F00017F80007F00007F;

  typedef enum {
    CFGNVM_IDLE,
    CFGNVM_ENTRY,
    CFGNVM_BUF,
    CFGNVM_NVM
  } cfgnvm_state_e;

  typedef struct packed {
    logic          wr;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
  } cfgnvm_reg_req_s;

  typedef struct packed {
    logic          req;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
  } cfgnvm_nvm_req_s;

  typedef struct packed {
    logic          ack;
    logic          err;
    logic [7:0]    rdata;
  } cfgnvm_nvm_rsp_s;

  typedef struct packed {
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
  } cfgnvm_buf_req_s;

endpackage

// [test/cfgnvm_nvm_model.sv]
`timescale 1ns/1ps
module cfgnvm_nvm_model (
  input  wire logic                        ref_clk,
  input  wire cfgnvm_pkg::cfgnvm_nvm_req_s nvm_req,
  output cfgnvm_pkg::cfgnvm_nvm_rsp_s      nvm_rsp,
  input  wire logic [3:0]                  lat,
  input  wire logic                        err_inj
);
  logic [7:0] mem [4096];
  logic [3:0] wait_q = 4'h0;
  logic [7:0] last_q = 8'h00;
  initial begin
    nvm_rsp = '0;
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
  end
  // Released read data shows the inverse of the last byte, never a stale copy
  always @(posedge ref_clk) begin
    nvm_rsp.ack <= 1'b0;
    nvm_rsp.err <= 1'b0;
    nvm_rsp.rdata <= ~last_q;
    if (nvm_req.req && !nvm_rsp.ack) begin
      if (wait_q < lat) wait_q <= wait_q + 4'h1;
      else begin
        wait_q <= 4'h0;
        nvm_rsp.ack <= 1'b1;
        nvm_rsp.err <= err_inj;
        nvm_rsp.rdata <= mem[nvm_req.addr];
        last_q <= mem[nvm_req.addr];
        if (nvm_req.we) mem[nvm_req.addr] <= nvm_req.wdata;
      end
    end
  end
endmodule // cfgnvm_nvm_model

// [test/cfgnvm_ctrl_tb.sv]
`timescale 1ns/1ps
module cfgnvm_ctrl_tb;
  logic                        ref_clk = 1'b0;
  logic                        reset = 1'b1;
  cfgnvm_pkg::cfgnvm_reg_req_s reg_req = '0;
  logic [7:0]                  reg_rdata;
  logic                        nvm_sel_n = 1'b1;
  logic                        status_sel = 1'b1;
  logic                        status_pin, apply_staged, soft_reset;
  cfgnvm_pkg::cfgnvm_buf_req_s buf_req;
  cfgnvm_pkg::cfgnvm_nvm_req_s nvm_req;
  cfgnvm_pkg::cfgnvm_nvm_rsp_s nvm_rsp;
  logic [3:0]                  lat = 4'h0;
  logic                        err_inj = 1'b0;
  logic [7:0]                  bufm [4096];
  logic [15:0]                 n_apply = '0, n_soft = '0, n_ack = '0, s0, s1;
  int                          failures = 0, n_compared = 0, cyc = 0, d;
  logic [11:0] ra [10] = '{12'h232, 12'hA00, 12'hA05, 12'hA0C, 12'hA0F, 12'hA10,
                           12'hB00, 12'hB01, 12'hB02, 12'hB03};
  logic [7:0]  rx [10] = '{8'h00, 8'h7F, 8'h80, 8'h3F, 8'h80, 8'hFF,
                           8'h00, 8'h00, 8'h00, 8'h00};
  cfgnvm_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .nvm_sel_n(nvm_sel_n), .status_sel(status_sel),
    .status_pin(status_pin), .apply_staged(apply_staged), .soft_reset(soft_reset),
    .buf_req(buf_req), .buf_rdata(bufm[buf_req.addr]), .nvm_req(nvm_req),
    .nvm_rsp(nvm_rsp));
  cfgnvm_nvm_model nvm_u (.ref_clk(ref_clk), .nvm_req(nvm_req), .nvm_rsp(nvm_rsp),
    .lat(lat), .err_inj(err_inj));
  always #4 ref_clk = ~ref_clk;
  initial for (int i = 0; i < 4096; i++) bufm[i] = ~i[7:0];
  always @(posedge ref_clk) begin
    n_apply += 16'(apply_staged);
    n_soft += 16'(soft_reset);
    n_ack += 16'(nvm_rsp.ack);
    if (buf_req.we) bufm[buf_req.addr] = buf_req.wdata;
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Called at a falling edge; leaves one idle edge so strobes never re-assert at once
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    reg_req <= '{wr: 1'b1, addr: a, wdata: v};
    @(negedge ref_clk);
    reg_req.wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    reg_req.addr <= a;
    @(negedge ref_clk);
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 10000; i++) begin
      reg_req.addr <= cfgnvm_pkg::ADDR_STATUS;
      @(negedge ref_clk);
      if (reg_rdata === 8'h00) break;
    end
    chk({8'h00, reg_rdata}, 16'h0000);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    for (int r = 0; r < 10; r++) rdc(ra[r], rx[r]);
    wr(cfgnvm_pkg::ADDR_APPLY, 8'h01);
    chk(n_apply, 16'd1);
    rdc(cfgnvm_pkg::ADDR_APPLY, 8'h00);
    wr(cfgnvm_pkg::ADDR_STORE, 8'h01);
    rdc(cfgnvm_pkg::ADDR_STATUS, 8'h00);
    repeat (20) @(negedge ref_clk);
    chk(n_ack, 16'd0);
    wr(cfgnvm_pkg::ADDR_CONTROL, 8'h01);
    rdc(cfgnvm_pkg::ADDR_CONTROL, 8'h01);
    wr(cfgnvm_pkg::ADDR_STORE, 8'h01);
    rdc(cfgnvm_pkg::ADDR_STATUS, 8'h01);
    chk({15'h0000, status_pin}, 16'h0001);
    status_sel <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0000, status_pin}, 16'h0000);
    status_sel <= 1'b1;
    wait_idle();
    chk(n_apply, 16'd1);
    d = 0;
    for (int i = 0; i < 12'h240; i++) d += int'(nvm_u.mem[i] !== bufm[i]);
    chk(16'(d), 16'd0);
    chk(n_ack, 16'd576);
    rdc(cfgnvm_pkg::ADDR_STORE, 8'h00);
    rdc(cfgnvm_pkg::ADDR_ERROR, 8'h00);
    wr(12'hA00, 8'h01);
    wr(12'hA01, 8'h01);
    wr(12'hA02, 8'h00);
    wr(12'hA03, 8'hFF);
    rdc(12'hA03, 8'hFF);
    bufm[12'h100] = 8'hC3;
    bufm[12'h101] = 8'h3C;
    lat <= 4'h3;
    err_inj <= 1'b1;
    s0 = n_ack;
    wr(cfgnvm_pkg::ADDR_STORE, 8'h01);
    // Second store and a table write while busy are both ignored
    wr(cfgnvm_pkg::ADDR_STORE, 8'h01);
    wr(12'hA03, 8'h00);
    wait_idle();
    chk(n_ack - s0, 16'd2);
    rdc(12'hA03, 8'hFF);
    chk({nvm_u.mem[0], nvm_u.mem[1]}, 16'hC33C);
    rdc(cfgnvm_pkg::ADDR_ERROR, 8'h01);
    err_inj <= 1'b0;
    wr(cfgnvm_pkg::ADDR_CONTROL, 8'h03);
    chk(n_soft, 16'd0);
    wr(12'hA03, 8'h80);
    wr(12'hA04, 8'hFF);
    nvm_u.mem[0] = 8'hA5;
    nvm_u.mem[1] = 8'h5A;
    nvm_sel_n <= 1'b0;
    s1 = n_apply;
    wr(cfgnvm_pkg::ADDR_CONTROL, 8'h03);
    chk(n_soft, 16'd1);
    wait_idle();
    chk({bufm[12'h100], bufm[12'h101]}, 16'hA55A);
    chk(n_apply - s1, 16'd1);
    rdc(cfgnvm_pkg::ADDR_ERROR, 8'h00);
    rdc(cfgnvm_pkg::ADDR_CONTROL, 8'h01);
    // Mid-run reset restores protection and the default table
    reset <= 1'b1;
    repeat (2) @(negedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    rdc(cfgnvm_pkg::ADDR_CONTROL, 8'h00);
    rdc(12'hA03, 8'h7F);
    results();
  end
endmodule // cfgnvm_ctrl_tb
